// ---- rtl/ssp_port.sv ----
// Purpose: Serial frame port, transmit and receive sections
// Assumes: cfg is quasi-static; change it only while the link is idle
// Notes:   Section 0 transmits; section 1 receives unless sync_mode is set, when receive uses section 0
`timescale 1ns/100ps
module ssp_port
    import ssp_pkg::*;
#(
    parameter int DIV = DIV_RST
)
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              link_clk,
    input  wire ssp_cfg_s          cfg,
    input  wire logic              wr_valid,
    input  wire logic [SLOT_W-1:0] wr_slot,
    input  wire logic [WORD_W-1:0] wr_data,
    output logic                   wr_ready,
    output logic                   rx_valid,
    output logic      [SLOT_W-1:0] rx_slot,
    output logic      [WORD_W-1:0] rx_data,
    output ssp_pin_s               tx_pin,
    output logic                   rx_bclk,
    output logic                   rx_fs,
    input  wire logic              rxd
);

    // ****************************************
    // Core domain
    // ****************************************
    logic              wr_tgl_q;
    logic [SLOT_W-1:0] wr_slot_q;
    logic [WORD_W-1:0] wr_data_q;
    logic [1:0]        ack_q;
    logic [2:0]        rxt_q;
    logic              rx_valid_q;
    logic [SLOT_W-1:0] rx_slot_q;
    logic [WORD_W-1:0] rx_data_q;
    logic              ack_tgl_q;
    logic              rx_tgl_q;
    logic [SLOT_W-1:0] rx_slot_l_q;
    logic [WORD_W-1:0] rx_word_l_q;

    // Ready only once the link side has taken the previous word
    assign wr_ready = (wr_tgl_q == ack_q[1]);

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            wr_tgl_q  <= 1'b0;
            wr_slot_q <= SLOT_RST;
            wr_data_q <= '0;
        end
        else if (wr_valid && wr_ready)
        begin
            wr_tgl_q  <= ~wr_tgl_q;
            wr_slot_q <= wr_slot;
            wr_data_q <= wr_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ack_q <= 2'h0;
            rxt_q <= 3'h0;
        end
        else
        begin
            ack_q <= {ack_q[0], ack_tgl_q};
            rxt_q <= {rxt_q[1:0], rx_tgl_q};
        end
    end

    // Received word is latched on the link side with the toggle and held long after it
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rx_valid_q <= 1'b0;
            rx_slot_q  <= SLOT_RST;
            rx_data_q  <= '0;
        end
        else
        begin
            rx_valid_q <= rxt_q[2] ^ rxt_q[1];
            if (rxt_q[2] ^ rxt_q[1])
            begin
                rx_slot_q <= rx_slot_l_q;
                rx_data_q <= rx_word_l_q;
            end
        end
    end

    assign rx_valid = rx_valid_q;
    assign rx_slot  = rx_slot_q;
    assign rx_data  = rx_data_q;

    // ****************************************
    // Link domain: reset, config, write path
    // ****************************************
    logic [1:0]        lrst_q;
    logic              lrst_n;
    ssp_cfg_s          cfg_m_q;
    ssp_cfg_s          cfg_l_q;
    logic [1:0]        req_q;
    logic              new_wr;
    logic              gated_eff;
    logic [SLOT_W-1:0] last_slot;
    logic              pend_q;
    logic              pend_dly_q;
    logic              act_q;
    logic              start;
    logic              run;
    logic [WORD_W-1:0] rdata_q;
    logic [SLOT_W-1:0] raddr;

    assign lrst_n = lrst_q[1];

    always_ff @(posedge link_clk)
    begin
        lrst_q <= {lrst_q[0], resetn};
    end

    always_ff @(posedge link_clk)
    begin
        cfg_m_q <= cfg;
        cfg_l_q <= cfg_m_q;
    end

    assign gated_eff = cfg_l_q.gated & ~cfg_l_q.network;
    always_comb
    begin
        if (!cfg_l_q.network)
            last_slot = SLOT_RST;
        else if (cfg_l_q.slots_m1 < MIN_LAST)
            last_slot = MIN_LAST;
        else
            last_slot = cfg_l_q.slots_m1;
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_n)
        begin
            req_q     <= 2'h0;
            ack_tgl_q <= 1'b0;
        end
        else
        begin
            req_q <= {req_q[0], wr_tgl_q};
            if (new_wr)
                ack_tgl_q <= req_q[1];
        end
    end

    assign new_wr = (req_q[1] != ack_tgl_q);

    ssp_slot_mem #(
        .W     (WORD_W),
        .DEPTH (MAX_SLOTS),
        .AW    (SLOT_W)
    ) u_mem (
        .clk     (link_clk),
        .we      (new_wr),
        .waddr   (wr_slot_q),
        .wdata   (wr_data_q),
        .raddr   (raddr),
        .rdata_q (rdata_q)
    );

    // ****************************************
    // Section timing, one per section
    // ****************************************
    logic [7:0]        div_q  [2];
    logic [1:0]        bclk_q;
    logic [1:0]        fs_q;
    logic [SLOT_W-1:0] slot_q [2];
    logic [4:0]        bit_q  [2];
    logic [1:0]        rise;
    logic [1:0]        fall;
    logic [1:0]        lbit;
    logic [1:0]        wend;
    logic [1:0]        lslot;
    logic              rs;

    // Gated clock runs only while a transfer is active
    assign run   = ~gated_eff | act_q;
    assign start = gated_eff & ~act_q & pend_q & pend_dly_q;

    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_sec
            logic tick;
            assign tick     = (div_q[s] == 8'(DIV - 1));
            assign rise[s]  = run & tick & ~bclk_q[s];
            assign fall[s]  = run & tick & bclk_q[s];
            assign lbit[s]  = (bit_q[s] == 5'(WORD_W - 1));
            assign lslot[s] = (slot_q[s] == last_slot);
            assign wend[s]  = fall[s] & lbit[s];

            always_ff @(posedge link_clk)
            begin
                if (!lrst_n || !run)
                begin
                    div_q[s]  <= 8'h00;
                    bclk_q[s] <= 1'b0;
                    bit_q[s]  <= 5'h00;
                    slot_q[s] <= SLOT_RST;
                    fs_q[s]   <= lrst_n ? start : 1'b1;
                end
                else
                begin
                    div_q[s] <= tick ? 8'h00 : div_q[s] + 8'h01;
                    if (tick)
                        bclk_q[s] <= ~bclk_q[s];
                    if (fall[s])
                    begin
                        bit_q[s] <= lbit[s] ? 5'h00 : bit_q[s] + 5'h01;
                        fs_q[s]  <= lbit[s] & lslot[s];
                    end
                    if (wend[s])
                        slot_q[s] <= lslot[s] ? SLOT_RST
                                              : slot_q[s] + 5'h01;
                end
            end
        end
    endgenerate

    // ****************************************
    // Transmit section
    // ****************************************
    logic [WORD_W-1:0] tsh_q;
    logic              txd_q;

    // Address runs one slot ahead during the last bit so data are ready
    assign raddr = !run ? SLOT_RST :
                   !lbit[0] ? slot_q[0] :
                   lslot[0] ? SLOT_RST : slot_q[0] + 5'h01;

    // A new word wins over the clear of the same cycle
    always_ff @(posedge link_clk)
    begin
        if (!lrst_n)
        begin
            pend_q     <= 1'b0;
            pend_dly_q <= 1'b0;
            act_q      <= 1'b0;
        end
        else
        begin
            pend_dly_q <= pend_q & ~new_wr;
            if (new_wr)
                pend_q <= 1'b1;
            else if (start || (act_q && wend[0]))
                pend_q <= 1'b0;
            if (start)
                act_q <= 1'b1;
            else if (wend[0] && lslot[0] && !pend_q)
                act_q <= 1'b0;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_n)
        begin
            tsh_q <= '0;
            txd_q <= 1'b0;
        end
        else if (!run || wend[0])
        begin
            tsh_q <= rdata_q;
            txd_q <= rdata_q[WORD_W-1];
        end
        else if (fall[0])
        begin
            tsh_q <= {tsh_q[WORD_W-2:0], 1'b0};
            txd_q <= tsh_q[WORD_W-2];
        end
    end

    assign tx_pin.bclk = bclk_q[0];
    assign tx_pin.fs   = fs_q[0];
    assign tx_pin.dat  = txd_q;

    // ****************************************
    // Receive section
    // ****************************************
    logic [1:0]        rxd_q;
    logic [WORD_W-1:0] rsh_q;
    logic              r_rise;
    logic              r_lbit;
    logic [SLOT_W-1:0] r_slot;

    assign rs      = ~cfg_l_q.sync_mode;
    assign r_rise  = rs ? rise[1] : rise[0];
    assign r_lbit  = rs ? lbit[1] : lbit[0];
    assign r_slot  = rs ? slot_q[1] : slot_q[0];
    assign rx_bclk = rs ? bclk_q[1] : bclk_q[0];
    assign rx_fs   = rs ? fs_q[1] : fs_q[0];

    always_ff @(posedge link_clk)
    begin
        rxd_q <= {rxd_q[0], rxd};
    end

    // Sampled at the rising edge with the pin value from two link cycles before it; needs DIV of 4 or more
    always_ff @(posedge link_clk)
    begin
        if (!lrst_n)
        begin
            rsh_q       <= '0;
            rx_tgl_q    <= 1'b0;
            rx_slot_l_q <= SLOT_RST;
            rx_word_l_q <= '0;
        end
        else if (r_rise)
        begin
            rsh_q <= {rsh_q[WORD_W-2:0], rxd_q[1]};
            if (r_lbit)
            begin
                rx_word_l_q <= {rsh_q[WORD_W-2:0], rxd_q[1]};
                rx_slot_l_q <= r_slot;
                rx_tgl_q    <= ~rx_tgl_q;
            end
        end
    end

endmodule : ssp_port

// ---- rtl/ssp_pkg.sv ----
// Purpose: Shared constants and types of the serial frame port
// Assumes: The port masters bit clocks and frame syncs on its pins
// Notes:   Functional notes follow
package ssp_pkg;

    // ****************************************
    // Constants
    // ****************************************
    localparam int            WORD_W    = 16;
    localparam int            SLOT_W    = 5;
    localparam int            MAX_SLOTS = 32;
    localparam int            DIV_RST   = 4;
    localparam logic [SLOT_W-1:0] SLOT_RST  = 5'h00;
    localparam logic [SLOT_W-1:0] MIN_LAST  = 5'h01;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed
    {
        logic              sync_mode;
        logic              gated;
        logic              network;
        logic [SLOT_W-1:0] slots_m1;
    } ssp_cfg_s;

    typedef struct packed
    {
        logic bclk;
        logic fs;
        logic dat;
    } ssp_pin_s;

endpackage : ssp_pkg

// ---- rtl/ssp_slot_mem.sv ----
// Purpose: Word store for transmit slots, registered read
// Assumes: Single clock, one write and one read port
// Notes:   Read data lag the address by one edge
`timescale 1ns/100ps
module ssp_slot_mem
    import ssp_pkg::*;
#(
    parameter int W     = WORD_W,
    parameter int DEPTH = MAX_SLOTS,
    parameter int AW    = SLOT_W
)
(
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata_q
);

    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        rdata_q <= mem[raddr];
    end

endmodule : ssp_slot_mem

// ---- tb/ssp_port_checker.sv ----
// Purpose: Pin and stream assertions for the serial frame port
// Assumes: cfg changes only while resetn is low
// Notes:   Link checks on link_clk, stream checks on core_clk
`timescale 1ns/100ps
module ssp_port_checker
    import ssp_pkg::*;
#(
    parameter int DIV = DIV_RST
)
(
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic              link_clk,
    input wire ssp_cfg_s          cfg,
    input wire logic              rx_valid,
    input wire logic [SLOT_W-1:0] rx_slot,
    input wire ssp_pin_s          tx_pin,
    input wire logic              rx_bclk,
    input wire logic              rx_fs
);
    logic [SLOT_W-1:0] last, nxt_q;
    logic [9:0]        nbits, rises_q;
    logic [3:0]        st_q, rst_q;
    logic              cont, rise, pb_q, prb_q, started_q;

    always_comb
    begin
        last  = !cfg.network ? SLOT_RST :
                (cfg.slots_m1 == SLOT_RST ? MIN_LAST : cfg.slots_m1);
        nbits = (10'(last) + 10'h001) * 10'h010;
        cont  = !cfg.gated || cfg.network;
        rise  = tx_pin.bclk && !pb_q;
    end
    // Counters restart in reset, so the link's reset lag is bounded
    always_ff @(posedge link_clk)
    begin
        pb_q      <= tx_pin.bclk;
        prb_q     <= rx_bclk;
        st_q      <= (!resetn || tx_pin.bclk != pb_q) ? 4'h0 : st_q + 4'h1;
        rst_q     <= (!resetn || rx_bclk != prb_q) ? 4'h0 : rst_q + 4'h1;
        rises_q   <= !resetn ? 10'h000 : !rise ? rises_q :
                     tx_pin.fs ? 10'h001 : rises_q + 10'h001;
        started_q <= resetn && (started_q || (rise && tx_pin.fs));
    end
    always_ff @(posedge core_clk)
        nxt_q <= !resetn ? SLOT_RST : !rx_valid ? nxt_q :
                 rx_slot == last ? SLOT_RST : rx_slot + 5'h01;

    chk_sync_share: assert property (@(posedge link_clk)
        disable iff (!resetn) cfg.sync_mode |->
        rx_bclk == tx_pin.bclk && rx_fs == tx_pin.fs)
        else $error("rx clock or sync differs from tx");
    chk_tx_runs: assert property (@(posedge link_clk)
        disable iff (!resetn) cont |-> st_q < 4'(DIV + 4))
        else $error("tx bit clock stopped");
    chk_rx_runs: assert property (@(posedge link_clk)
        disable iff (!resetn) cont |-> rst_q < 4'(DIV + 4))
        else $error("rx bit clock stopped");
    chk_frame_len: assert property (@(posedge link_clk)
        disable iff (!resetn) rise && !tx_pin.fs |-> rises_q < nbits)
        else $error("bit clock beyond frame");
    chk_frame_full: assert property (@(posedge link_clk)
        disable iff (!resetn) rise && tx_pin.fs && started_q |->
        rises_q == nbits)
        else $error("frame length wrong");
    // A gated link drops its sync while the clock is idle, so only the
    // running continuous clock ties the sync edge to a falling edge
    chk_fs_edge: assert property (@(posedge link_clk)
        disable iff (!resetn) $fell(tx_pin.fs) && cont && started_q
        |-> $fell(tx_pin.bclk))
        else $error("frame sync ends off a falling edge");
    chk_dat_edge: assert property (@(posedge link_clk)
        disable iff (!resetn) started_q && cont && $changed(tx_pin.dat)
        |-> $fell(tx_pin.bclk))
        else $error("tx data moved off a falling edge");
    chk_rx_order: assert property (@(posedge core_clk)
        disable iff (!resetn) rx_valid |-> rx_slot == nxt_q)
        else $error("rx slot out of order");
    chk_rx_pulse: assert property (@(posedge core_clk)
        disable iff (!resetn) rx_valid |=> !rx_valid)
        else $error("rx valid longer than one cycle");

    cover property (@(posedge core_clk) rx_valid && rx_slot == 5'h1f);
    cover property (@(posedge link_clk) cfg.gated && !cfg.network && rise);
    cover property (@(posedge core_clk) !cfg.sync_mode && rx_valid);
endmodule : ssp_port_checker

bind ssp_port ssp_port_checker #(.DIV(DIV)) u_chk
(
    .core_clk(core_clk), .resetn(resetn), .link_clk(link_clk), .cfg(cfg),
    .rx_valid(rx_valid), .rx_slot(rx_slot), .tx_pin(tx_pin),
    .rx_bclk(rx_bclk), .rx_fs(rx_fs)
);

// ---- tb/ssp_codec_model.sv ----
// Purpose: Far-end codec: sends a slot pattern, captures tx words
// Assumes: Capture timing follows the rx clock, so valid in sync mode
// Notes:   Pattern per slot is fixed so the bench can predict it
`timescale 1ns/100ps
module ssp_codec_model
    import ssp_pkg::*;
(
    input  wire logic         link_clk,
    input  wire logic         bclk,
    input  wire logic         fs,
    input  wire logic         txd,
    output logic              rxd,
    output logic              cap_valid,
    output logic [SLOT_W-1:0] cap_slot,
    output logic [WORD_W-1:0] cap_word
);
    logic [3:0]        idx_q  = 4'h0;
    logic [SLOT_W-1:0] slot_q = 5'h00;
    logic [WORD_W-1:0] sh_q   = 16'h0000;
    logic [WORD_W-1:0] pat;
    logic              pb_q   = 1'b0;

    always_ff @(posedge link_clk)
    begin
        pb_q      <= bclk;
        cap_valid <= 1'b0;
        if (fs && !bclk)
        begin
            idx_q  <= 4'h0;
            slot_q <= 5'h00;
        end
        else if (pb_q && !bclk)
        begin
            idx_q  <= idx_q + 4'h1;
            slot_q <= slot_q + 5'(idx_q == 4'hf);
        end
        if (bclk && !pb_q)
        begin
            sh_q      <= {sh_q[14:0], txd};
            cap_valid <= idx_q == 4'hf;
            cap_slot  <= slot_q;
            cap_word  <= {sh_q[14:0], txd};
        end
    end
    assign pat = 16'ha5c3 + 16'(slot_q) * 16'h0111;
    assign rxd = pat[4'hf - idx_q];
endmodule : ssp_codec_model

// ---- tb/sync_serial_frame_port_bench.sv ----
// Purpose: Self-checking bench for the serial frame port
// Assumes: Config changes only under reset
// Notes:   Queues hold expected words, watchers compare them
`timescale 1ns/100ps
module sync_serial_frame_port_bench
    import ssp_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              link_clk = 1'b0;
    logic              resetn   = 1'b0;
    ssp_cfg_s          cfg      = 8'h80;
    logic              wr_valid = 1'b0;
    logic [SLOT_W-1:0] wr_slot  = 5'h00;
    logic [WORD_W-1:0] wr_data  = 16'h0000;
    logic              wr_ready, rx_valid, rxd, cap_valid, rx_bclk, rx_fs;
    logic [SLOT_W-1:0] rx_slot, cap_slot;
    logic [WORD_W-1:0] rx_data, cap_word;
    ssp_pin_s          tx_pin;
    logic [20:0]       rxq[$], txq[$];
    logic [15:0]       mem [32];
    // Gated clocking is never asked for together with network framing
    logic [7:0]        cfgs [6] = '{8'h80, 8'hbf, 8'ha0, 8'hc0, 8'ha2, 8'h23};
    int                n_mismatch = 0;
    int                n_compared = 0;

    initial forever #10 core_clk = ~core_clk;
    initial
    begin
        #3;
        forever #6 link_clk = ~link_clk;
    end

    ssp_port #(.DIV(4)) dut
    (
        .core_clk(core_clk), .resetn(resetn), .link_clk(link_clk),
        .cfg(cfg), .wr_valid(wr_valid), .wr_slot(wr_slot),
        .wr_data(wr_data), .wr_ready(wr_ready), .rx_valid(rx_valid),
        .rx_slot(rx_slot), .rx_data(rx_data), .tx_pin(tx_pin),
        .rx_bclk(rx_bclk), .rx_fs(rx_fs), .rxd(rxd)
    );
    ssp_codec_model u_codec
    (
        .link_clk(link_clk), .bclk(rx_bclk), .fs(rx_fs),
        .txd(tx_pin.dat), .rxd(rxd), .cap_valid(cap_valid),
        .cap_slot(cap_slot), .cap_word(cap_word)
    );

    task automatic check(input string nm, input logic [20:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic wr(input logic [4:0] s, input logic [15:0] d);
        int n;
        n        = 0;
        wr_valid = 1'b1;
        wr_slot  = s;
        wr_data  = d;
        while (wr_ready !== 1'b1 && n < 50)
        begin
            @(posedge core_clk) #1;
            n++;
        end
        @(posedge core_clk) #1;
        wr_valid = 1'b0;
        @(posedge core_clk) #1;
    endtask : wr

    // Sampled mid-cycle, away from the edge that launches the outputs
    always @(negedge core_clk)
        if (resetn && rx_valid === 1'b1 && rxq.size() > 0)
            check("rx word", rxq.pop_front(), {rx_slot, rx_data});
    always @(negedge link_clk)
        if (cap_valid === 1'b1 && txq.size() > 0)
            check("tx word", txq.pop_front(), {cap_slot, cap_word});

    initial
    begin
        #2000000;
        n_mismatch++;
        $display("ERROR watchdog expected done seen running");
        results();
    end

    initial
    begin
        logic [4:0] last;
        int         n;
        void'($urandom(71));
        foreach (cfgs[i])
        begin
            @(posedge core_clk) #1;
            resetn = 1'b0;
            cfg    = cfgs[i];
            last   = !cfg.network ? 5'h00 :
                     (cfg.slots_m1 == 5'h00 ? 5'h01 : cfg.slots_m1);
            repeat (16) @(posedge core_clk);
            for (int s = 0; s <= last; s++)
                rxq.push_back({5'(s), 16'ha5c3 + 16'(s) * 16'h0111});
            #1;
            resetn = 1'b1;
            for (int s = 0; s <= last; s++)
            begin
                mem[s] = 16'($urandom);
                wr(5'(s), mem[s]);
            end
            // Gated: the write itself launches the one frame
            if (cfg.gated && !cfg.network)
                txq.push_back({5'h00, mem[0]});
            else if (cfg.sync_mode)
            begin
                n = 0;
                while (!(cap_valid === 1'b1 && cap_slot === last) && n < 20000)
                begin
                    @(posedge link_clk);
                    n++;
                end
                @(posedge link_clk) #1;
                for (int s = 0; s <= last; s++)
                    txq.push_back({5'(s), mem[s]});
            end
            n = 0;
            while ((rxq.size() > 0 || txq.size() > 0) && n < 12000)
            begin
                @(posedge core_clk);
                n++;
            end
            check("queues drained", 21'h0, 21'(n >= 12000));
            rxq.delete();
            txq.delete();
        end
        results();
    end
endmodule : sync_serial_frame_port_bench
